// >>> scc_map.svh
/*
 * Register offsets, reset values, field positions and encodings of the
 * system clock configuration block.
 * Assumes byte addressing on a 32-bit APB, one aligned word per register.
 */
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH

// ====================================================================
// Register offsets (byte addresses)
`define SCC_OFF_MEM_REMAP        12'h000
`define SCC_OFF_PERIPH_RST_CTRL  12'h004
`define SCC_OFF_PLL_CTRL         12'h008
`define SCC_OFF_PLL_STATUS       12'h00C
`define SCC_OFF_XTAL_OSC_CTRL    12'h020
`define SCC_OFF_WDT_OSC_CTRL     12'h024
`define SCC_OFF_RST_CAUSE        12'h030
`define SCC_OFF_PLL_IN_SEL       12'h040
`define SCC_OFF_PLL_IN_UPD       12'h044
`define SCC_OFF_MAIN_CLK_SEL     12'h070
`define SCC_OFF_MAIN_CLK_UPD     12'h074
`define SCC_OFF_SYS_CLK_DIV      12'h078
`define SCC_OFF_CLK_GATE_CTRL    12'h080
`define SCC_OFF_SERIAL_CLK_DIV   12'h094
`define SCC_OFF_PIN_INT_SEL0     12'h178
`define SCC_OFF_PIN_INT_SEL7     12'h194
`define SCC_OFF_WAKE_EN          12'h214
`define SCC_OFF_POWER_RUN_CFG    12'h238

// ====================================================================
// Reset values (contents after the boot loader has run)
`define SCC_RST_MEM_REMAP        32'h0000_0002
`define SCC_RST_PERIPH_RST_CTRL  32'h0000_1FFF
`define SCC_RST_PLL_CTRL         32'h0000_0000
`define SCC_RST_XTAL_OSC_CTRL    32'h0000_0000
`define SCC_RST_WDT_OSC_CTRL     32'h0000_00A0
`define SCC_RST_PLL_IN_SEL       32'h0000_0000
`define SCC_RST_MAIN_CLK_SEL     32'h0000_0000
`define SCC_RST_SYS_CLK_DIV      32'h0000_0001
`define SCC_RST_CLK_GATE_CTRL    32'h0000_001F
`define SCC_RST_SERIAL_CLK_DIV   32'h0000_0000
`define SCC_RST_WAKE_EN          32'h0000_0000
`define SCC_RST_POWER_RUN_CFG    32'h0000_EDF0

// ====================================================================
// Fields and encodings
`define SCC_UPD_BIT              0
`define SCC_LOCK_BIT             0
`define SCC_SEL_W                2
`define SCC_DIV_W                8
`define SCC_PINSEL_W             8
`define SCC_PIN_INT_N            8
`define SCC_MAIN_SEL_IRC         2'h0
`define SCC_MAIN_SEL_PLL         2'h3

`endif

// >>> scc_pkg.sv
/*
 * Types of the system clock configuration block: APB request and answer
 * carriers and the state of the glitch-free clock switch.
 * Assumes scc_map.svh for all numeric constants.
 */
package scc_pkg;

    // ================================================================
    // APB carriers
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } scc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } scc_apb_rsp_t;

    // ================================================================
    // Main clock switch state
    typedef enum logic [0:0] {
        SCC_SW_RUN  = 1'b0,
        SCC_SW_PARK = 1'b1
    } scc_sw_state_t;

endpackage : scc_pkg

// >>> scc_system_clock_config.sv
/*
 * System clock configuration block: main clock selection with a
 * glitch-free switch, system and serial clock dividers, per-peripheral
 * clock enables and resets, analog power and wake-up configuration,
 * reached over APB.
 * Assumes the oscillator and PLL clocks arrive as asynchronous levels much
 * slower than ref_clk; clocks are regenerated as ref_clk-registered levels
 * and one-cycle enable ticks.
 */
// Register access over APB was chosen for this implementation.
// ====================================================================
// Overview of operation
// - Main clock comes from the 12 MHz internal oscillator or the PLL.
// - After reset the internal oscillator drives the main clock.
// - System clock is the main clock divided; it feeds core and peripherals.
// - A system divider of zero stops the system clock.
// - Core clock runs unless the system divider is zero; memory and peripheral clocks are gated.
// - Core and peripheral clocks share one frequency, except serial port.
// - All clocks made here except the wake-up timing oscillator.
// - A register asserts and releases each peripheral reset.
// - Eight pin interrupt sources each select any digital pin.
// - Power switches exist for oscillators, PLL, brown-out and comparator.
// - Wake enables let chosen interrupts wake the chip from deep sleep.
// - Registers are word aligned; undefined offsets are reserved.
// - Reset values equal the contents after the boot loader ran.
`timescale 1ns/100ps
`default_nettype none
`include "scc_map.svh"

module scc_system_clock_config
    import scc_pkg::*;
#(
    parameter int DIV_W = `SCC_DIV_W
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    // APB slave
    input  wire scc_apb_req_t       apb_req,
    output var  scc_apb_rsp_t       apb_rsp,
    // Clock sources and status from the analog side
    input  wire logic               internal_rc_oscillator,
    input  wire logic               pll_clk_in,
    input  wire logic               pll_lock_in,
    input  wire logic [31:0]        reset_cause_in,
    // Generated clocks
    output logic                    main_clk_q,
    output logic                    sys_clk_tick_q,
    output logic                    core_clk_en_q,
    output logic [31:0]             periph_clk_en_q,
    output logic                    serial_clk_tick_q,
    // Peripheral resets, active low
    output logic [31:0]             periph_rst_n_q,
    // Analog and configuration outputs
    output logic [31:0]             pll_ctrl_q,
    output logic [31:0]             xtal_osc_ctrl_q,
    output logic [31:0]             wdt_osc_ctrl_q,
    output logic [1:0]              mem_remap_q,
    output logic [1:0]              pll_in_active_q,
    output logic [15:0]             power_down_q,
    output logic [31:0]             wake_en_q,
    output logic [8*`SCC_PINSEL_W-1:0] pin_int_sel_q
);

    // ================================================================
    // Helpers
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction : hit

    function automatic logic upd_edge(input logic prev, input logic [31:0] wd);
        upd_edge = !prev && wd[`SCC_UPD_BIT];
    endfunction : upd_edge

    // ================================================================
    // Bus decode
    wire logic        acc   = apb_req.psel && apb_req.penable;
    wire logic        wr    = acc && apb_req.pwrite;
    wire logic [11:0] a     = apb_req.paddr;
    wire logic [31:0] wd    = apb_req.pwdata;
    wire logic        pinsel_hit = (a[11:2] >= `SCC_OFF_PIN_INT_SEL0 >> 2)
                                 && (a[11:2] <= `SCC_OFF_PIN_INT_SEL7 >> 2);
    wire logic [2:0]  pinsel_idx = 3'(a[11:2] - 10'(`SCC_OFF_PIN_INT_SEL0 >> 2));
    wire logic        mapped =
        hit(a, `SCC_OFF_MEM_REMAP)      || hit(a, `SCC_OFF_PERIPH_RST_CTRL) ||
        hit(a, `SCC_OFF_PLL_CTRL)       || hit(a, `SCC_OFF_PLL_STATUS)      ||
        hit(a, `SCC_OFF_XTAL_OSC_CTRL)  || hit(a, `SCC_OFF_WDT_OSC_CTRL)    ||
        hit(a, `SCC_OFF_RST_CAUSE)      || hit(a, `SCC_OFF_PLL_IN_SEL)      ||
        hit(a, `SCC_OFF_PLL_IN_UPD)     || hit(a, `SCC_OFF_MAIN_CLK_SEL)    ||
        hit(a, `SCC_OFF_MAIN_CLK_UPD)   || hit(a, `SCC_OFF_SYS_CLK_DIV)     ||
        hit(a, `SCC_OFF_CLK_GATE_CTRL)  || hit(a, `SCC_OFF_SERIAL_CLK_DIV)  ||
        hit(a, `SCC_OFF_WAKE_EN)        || hit(a, `SCC_OFF_POWER_RUN_CFG)   ||
        pinsel_hit;
    wire logic wr_ok = wr && mapped;

    // ================================================================
    // Registers
    logic [31:0]             periph_rst_ctrl_q;
    logic [31:0]             clk_gate_q;
    logic [31:0]             rst_cause_q;
    logic [1:0]              pll_in_sel_q;
    logic                    pll_in_upd_q;
    logic [1:0]              main_sel_q;
    logic                    main_upd_q;
    logic [1:0]              main_pend_q;
    logic [DIV_W-1:0]        sys_div_q;
    logic [DIV_W-1:0]        ser_div_q;
    logic [31:0]             prdata_q;
    logic                    pslverr_q;
    logic [`SCC_PINSEL_W-1:0] pin_sel_q [`SCC_PIN_INT_N];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mem_remap_q       <= 2'(`SCC_RST_MEM_REMAP);
            periph_rst_ctrl_q <= `SCC_RST_PERIPH_RST_CTRL;
            pll_ctrl_q        <= `SCC_RST_PLL_CTRL;
            xtal_osc_ctrl_q   <= `SCC_RST_XTAL_OSC_CTRL;
            wdt_osc_ctrl_q    <= `SCC_RST_WDT_OSC_CTRL;
            pll_in_sel_q      <= 2'(`SCC_RST_PLL_IN_SEL);
            main_sel_q        <= 2'(`SCC_RST_MAIN_CLK_SEL);
            sys_div_q         <= DIV_W'(`SCC_RST_SYS_CLK_DIV);
            clk_gate_q        <= `SCC_RST_CLK_GATE_CTRL;
            ser_div_q         <= DIV_W'(`SCC_RST_SERIAL_CLK_DIV);
            wake_en_q         <= `SCC_RST_WAKE_EN;
            power_down_q      <= 16'(`SCC_RST_POWER_RUN_CFG);
        end else if (wr_ok) begin
            if (hit(a, `SCC_OFF_MEM_REMAP))       mem_remap_q       <= wd[1:0];
            if (hit(a, `SCC_OFF_PERIPH_RST_CTRL)) periph_rst_ctrl_q <= wd;
            if (hit(a, `SCC_OFF_PLL_CTRL))        pll_ctrl_q        <= wd;
            if (hit(a, `SCC_OFF_XTAL_OSC_CTRL))   xtal_osc_ctrl_q   <= wd;
            if (hit(a, `SCC_OFF_WDT_OSC_CTRL))    wdt_osc_ctrl_q    <= wd;
            if (hit(a, `SCC_OFF_PLL_IN_SEL))      pll_in_sel_q      <= wd[1:0];
            if (hit(a, `SCC_OFF_MAIN_CLK_SEL))    main_sel_q        <= wd[1:0];
            if (hit(a, `SCC_OFF_SYS_CLK_DIV))     sys_div_q         <= wd[DIV_W-1:0];
            if (hit(a, `SCC_OFF_CLK_GATE_CTRL))   clk_gate_q        <= wd;
            if (hit(a, `SCC_OFF_SERIAL_CLK_DIV))  ser_div_q         <= wd[DIV_W-1:0];
            if (hit(a, `SCC_OFF_WAKE_EN))         wake_en_q         <= wd;
            if (hit(a, `SCC_OFF_POWER_RUN_CFG))   power_down_q      <= wd[15:0];
        end
    end

    // Pin interrupt selects, one byte each.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < `SCC_PIN_INT_N; i++) pin_sel_q[i] <= '0;
        end else if (wr_ok && pinsel_hit) begin
            pin_sel_q[pinsel_idx] <= wd[`SCC_PINSEL_W-1:0];
        end
    end

    always_comb begin
        for (int i = 0; i < `SCC_PIN_INT_N; i++)
            pin_int_sel_q[i*`SCC_PINSEL_W +: `SCC_PINSEL_W] = pin_sel_q[i];
    end

    // ================================================================
    // Update registers: a 0 to 1 write applies the pending selection.
    wire logic main_upd_wr = wr_ok && hit(a, `SCC_OFF_MAIN_CLK_UPD);
    wire logic pll_upd_wr  = wr_ok && hit(a, `SCC_OFF_PLL_IN_UPD);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            main_upd_q      <= 1'b0;
            pll_in_upd_q    <= 1'b0;
            main_pend_q     <= `SCC_MAIN_SEL_IRC;
            pll_in_active_q <= 2'(`SCC_RST_PLL_IN_SEL);
        end else begin
            if (main_upd_wr) begin
                main_upd_q <= wd[`SCC_UPD_BIT];
                if (upd_edge(main_upd_q, wd)) main_pend_q <= main_sel_q;
            end
            if (pll_upd_wr) begin
                pll_in_upd_q <= wd[`SCC_UPD_BIT];
                if (upd_edge(pll_in_upd_q, wd)) pll_in_active_q <= pll_in_sel_q;
            end
        end
    end

    // ================================================================
    // Input synchronisers
    logic [1:0] irc_s_q;
    logic [1:0] pll_s_q;
    logic [1:0] lock_s_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irc_s_q  <= 2'h0;
            pll_s_q  <= 2'h0;
            lock_s_q <= 2'h0;
        end else begin
            irc_s_q  <= {irc_s_q[0],  internal_rc_oscillator};
            pll_s_q  <= {pll_s_q[0],  pll_clk_in};
            lock_s_q <= {lock_s_q[0], pll_lock_in};
        end
    end

    // ================================================================
    // Glitch-free main clock switch. The output is parked low once the old
    // source is low and until the new source is low, so no pulse is ever cut short.
    scc_sw_state_t sw_q;
    logic          use_pll_q;
    wire logic     want_pll = (main_pend_q == `SCC_MAIN_SEL_PLL);
    wire logic     cur_lvl  = use_pll_q ? pll_s_q[1] : irc_s_q[1];
    wire logic     new_lvl  = want_pll ? pll_s_q[1] : irc_s_q[1];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sw_q       <= SCC_SW_RUN;
            use_pll_q  <= 1'b0;
            main_clk_q <= 1'b0;
        end else begin
            case (sw_q)
                SCC_SW_RUN: begin
                    main_clk_q <= cur_lvl;
                    if (want_pll != use_pll_q && !cur_lvl) begin
                        sw_q       <= SCC_SW_PARK;
                        main_clk_q <= 1'b0;
                    end
                end
                SCC_SW_PARK: begin
                    main_clk_q <= 1'b0;
                    if (!new_lvl) begin
                        use_pll_q <= want_pll;
                        sw_q      <= SCC_SW_RUN;
                    end
                end
                default: sw_q <= SCC_SW_RUN;
            endcase
        end
    end

    // ================================================================
    // Dividers, counted on main clock rising edges.
    logic             main_prev_q;
    logic [DIV_W-1:0] sys_cnt_q;
    logic [DIV_W-1:0] ser_cnt_q;
    wire logic        main_rise = main_clk_q && !main_prev_q;
    wire logic        sys_wrap  = (sys_cnt_q >= sys_div_q - DIV_W'(1));
    wire logic        ser_wrap  = (ser_cnt_q >= ser_div_q - DIV_W'(1));

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            main_prev_q       <= 1'b0;
            sys_cnt_q         <= '0;
            ser_cnt_q         <= '0;
            sys_clk_tick_q    <= 1'b0;
            serial_clk_tick_q <= 1'b0;
        end else begin
            main_prev_q       <= main_clk_q;
            sys_clk_tick_q    <= 1'b0;
            serial_clk_tick_q <= 1'b0;
            if (sys_div_q == '0) begin
                sys_cnt_q <= '0;
            end else if (main_rise) begin
                sys_cnt_q      <= sys_wrap ? '0 : sys_cnt_q + DIV_W'(1);
                sys_clk_tick_q <= sys_wrap;
            end
            if (ser_div_q == '0) begin
                ser_cnt_q <= '0;
            end else if (main_rise) begin
                ser_cnt_q         <= ser_wrap ? '0 : ser_cnt_q + DIV_W'(1);
                serial_clk_tick_q <= ser_wrap;
            end
        end
    end

    // Core enable follows every system tick; peripherals only when gated on.
    always_comb begin
        core_clk_en_q   = sys_clk_tick_q;
        periph_clk_en_q = {32{sys_clk_tick_q}} & clk_gate_q;
        periph_rst_n_q  = periph_rst_ctrl_q;
    end

    // ================================================================
    // Reset cause: hardware sets, software clears by writing ones.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_cause_q <= '0;
        end else begin
            rst_cause_q <= (rst_cause_q
                & ~((wr_ok && hit(a, `SCC_OFF_RST_CAUSE)) ? wd : 32'h0000_0000))
                | reset_cause_in;
        end
    end

    // ================================================================
    // Read path
    function automatic logic [31:0] rd_mux(input logic [11:0] ad);
        rd_mux = 32'h0000_0000;
        if (hit(ad, `SCC_OFF_MEM_REMAP))       rd_mux = {30'h0, mem_remap_q};
        if (hit(ad, `SCC_OFF_PERIPH_RST_CTRL)) rd_mux = periph_rst_ctrl_q;
        if (hit(ad, `SCC_OFF_PLL_CTRL))        rd_mux = pll_ctrl_q;
        if (hit(ad, `SCC_OFF_PLL_STATUS))      rd_mux = {31'h0, lock_s_q[1]};
        if (hit(ad, `SCC_OFF_XTAL_OSC_CTRL))   rd_mux = xtal_osc_ctrl_q;
        if (hit(ad, `SCC_OFF_WDT_OSC_CTRL))    rd_mux = wdt_osc_ctrl_q;
        if (hit(ad, `SCC_OFF_RST_CAUSE))       rd_mux = rst_cause_q;
        if (hit(ad, `SCC_OFF_PLL_IN_SEL))      rd_mux = {30'h0, pll_in_sel_q};
        if (hit(ad, `SCC_OFF_PLL_IN_UPD))      rd_mux = {31'h0, pll_in_upd_q};
        if (hit(ad, `SCC_OFF_MAIN_CLK_SEL))    rd_mux = {30'h0, main_sel_q};
        if (hit(ad, `SCC_OFF_MAIN_CLK_UPD))    rd_mux = {31'h0, main_upd_q};
        if (hit(ad, `SCC_OFF_SYS_CLK_DIV))     rd_mux = 32'(sys_div_q);
        if (hit(ad, `SCC_OFF_CLK_GATE_CTRL))   rd_mux = clk_gate_q;
        if (hit(ad, `SCC_OFF_SERIAL_CLK_DIV))  rd_mux = 32'(ser_div_q);
        if (hit(ad, `SCC_OFF_WAKE_EN))         rd_mux = wake_en_q;
        if (hit(ad, `SCC_OFF_POWER_RUN_CFG))   rd_mux = {16'h0, power_down_q};
    endfunction : rd_mux

    logic [31:0] rd_word;

    // A procedure rather than a net assignment, so that the registers read
    // inside the mux function are part of the sensitivity.
    always_comb begin
        rd_word = pinsel_hit ? 32'(pin_sel_q[pinsel_idx]) : rd_mux(a);
    end

    // Read data is captured in the setup phase so the access phase is one cycle.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else if (apb_req.psel && !apb_req.penable) begin
            prdata_q  <= apb_req.pwrite ? 32'h0000_0000 : rd_word;
            pslverr_q <= !mapped;
        end
    end

    always_comb begin
        apb_rsp.prdata  = prdata_q;
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = pslverr_q && acc;
    end

    // The wake-up timing oscillator is owned by power management; no control here.

endmodule : scc_system_clock_config
`default_nettype wire

// >>> scc_system_clock_config_sva.sv
/* Checker of the system clock configuration block, bound to its top.
   Assumes sources slower than ref_clk/4 and a three-cycle follow delay. */
`timescale 1ns/100ps
`default_nettype none
`include "scc_map.svh"
module scc_system_clock_config_sva
    import scc_pkg::*;
(
    // Clock, reset and bus
    input wire logic         ref_clk,
    input wire logic         rstn,
    input wire scc_apb_req_t apb_req,
    input wire scc_apb_rsp_t apb_rsp,
    // Source and generated clocks
    input wire logic         internal_rc_oscillator,
    input wire logic         main_clk_q,
    input wire logic         sys_clk_tick_q,
    input wire logic         core_clk_en_q,
    input wire logic [31:0]  periph_clk_en_q,
    input wire logic         serial_clk_tick_q,
    // Configuration outputs
    input wire logic [31:0]  periph_rst_n_q,
    input wire logic [15:0]  power_down_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // ================================================================
    // Helper state
    logic       upd_seen_q;
    logic [1:0] age_q;
    wire        acc = apb_req.psel && apb_req.penable;
    wire        upd_wr = acc && apb_req.pwrite && apb_req.paddr == `SCC_OFF_MAIN_CLK_UPD;
    // Any main clock update write ends the default-source check; the switch timing is free.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            upd_seen_q <= 1'b0;
            age_q      <= 2'h0;
        end else begin
            upd_seen_q <= upd_seen_q | upd_wr;
            age_q      <= (age_q == 2'h3) ? age_q : age_q + 2'h1;
        end
    end
    // ================================================================
    // Assertions
    AST_RC_DEFAULT: assert property (age_q == 2'h3 && !upd_seen_q |->
        main_clk_q == $past(internal_rc_oscillator, 3))
        else $error("main clock does not follow the internal oscillator");
    AST_READY: assert property (acc |-> apb_rsp.pready)
        else $error("access phase not answered");
    AST_ERR_PHASE: assert property (!acc |-> !apb_rsp.pslverr)
        else $error("error flag outside access phase");
    AST_CORE: assert property (core_clk_en_q == sys_clk_tick_q)
        else $error("core enable differs from system tick");
    AST_GATE: assert property (!sys_clk_tick_q |-> periph_clk_en_q == 32'h0)
        else $error("peripheral enable without system tick");
    AST_TICK_ONE: assert property (sys_clk_tick_q |=> !sys_clk_tick_q)
        else $error("system tick longer than one cycle");
    AST_TICK_SRC: assert property (sys_clk_tick_q |->
        $past(main_clk_q, 1) || $past(main_clk_q, 2))
        else $error("system tick without main clock high");
    AST_NO_RUNT: assert property ($rose(main_clk_q) |=> main_clk_q)
        else $error("runt high pulse on main clock");
    AST_NO_GLITCH: assert property ($fell(main_clk_q) |=> !main_clk_q)
        else $error("glitch low pulse on main clock");
    AST_SER_ONE: assert property (serial_clk_tick_q |=> !serial_clk_tick_q)
        else $error("serial tick longer than one cycle");
    AST_RST_VAL: assert property ($rose(rstn) |->
        periph_rst_n_q == `SCC_RST_PERIPH_RST_CTRL && power_down_q == 16'hEDF0)
        else $error("reset values wrong at release");
    cover property (sys_clk_tick_q);
    cover property (acc && apb_rsp.pslverr);
    cover property ($fell(main_clk_q) && upd_seen_q);
endmodule : scc_system_clock_config_sva
`default_nettype wire

// >>> scc_system_clock_config_test.sv
/* Self-checking bench of the system clock configuration block.
   Assumes a zero-wait APB slave and sources much slower than ref_clk. */
`timescale 1ns/100ps
`default_nettype none
module scc_system_clock_config_test import scc_pkg::*;;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] r;
        logic [31:0] w;
        logic [31:0] q;
        logic        e;
    } scc_row_t;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    scc_apb_req_t apb_req = '0;
    scc_apb_rsp_t apb_rsp;
    logic internal_rc_oscillator = 1'b0;
    logic pll_clk_in = 1'b0;
    logic pll_lock_in = 1'b0;
    logic [31:0] reset_cause_in = 32'h0;
    logic main_clk_q, sys_clk_tick_q, core_clk_en_q, serial_clk_tick_q;
    logic [31:0] periph_clk_en_q, periph_rst_n_q, pll_ctrl_q, xtal_osc_ctrl_q;
    logic [31:0] wdt_osc_ctrl_q, wake_en_q;
    logic [1:0] mem_remap_q, pll_in_active_q;
    logic [15:0] power_down_q;
    logic [63:0] pin_int_sel_q;
    logic [31:0] c;
    int mismatches = 0;
    int samples_checked = 0;
    int ph = 0;
    scc_row_t rows [15] = '{
        '{12'h000, 32'h2, 32'h1, 32'h1, 1'b0}, '{12'h004, 32'h1FFF, 32'hAAA, 32'hAAA, 1'b0},
        '{12'h008, 32'h0, 32'h23, 32'h23, 1'b0}, '{12'h00C, 32'h0, 32'hFFFF, 32'h0, 1'b0},
        '{12'h020, 32'h0, 32'h3, 32'h3, 1'b0}, '{12'h024, 32'hA0, 32'h41, 32'h41, 1'b0},
        '{12'h030, 32'h0, 32'h0, 32'h0, 1'b0}, '{12'h078, 32'h1, 32'h1, 32'h1, 1'b0},
        '{12'h080, 32'h1F, 32'h1F, 32'h1F, 1'b0}, '{12'h094, 32'h0, 32'h2, 32'h2, 1'b0},
        '{12'h178, 32'h0, 32'h5A, 32'h5A, 1'b0}, '{12'h194, 32'h0, 32'hA5, 32'hA5, 1'b0},
        '{12'h214, 32'h0, 32'h81, 32'h81, 1'b0}, '{12'h238, 32'hEDF0, 32'hDF0, 32'hDF0, 1'b0},
        '{12'h010, 32'h0, 32'hFFFF, 32'h0, 1'b1}};
    scc_system_clock_config scc_system_clock_config_inst (.ref_clk, .rstn, .apb_req,
        .apb_rsp, .internal_rc_oscillator, .pll_clk_in, .pll_lock_in, .reset_cause_in,
        .main_clk_q, .sys_clk_tick_q, .core_clk_en_q, .periph_clk_en_q, .serial_clk_tick_q,
        .periph_rst_n_q, .pll_ctrl_q, .xtal_osc_ctrl_q, .wdt_osc_ctrl_q, .mem_remap_q,
        .pll_in_active_q, .power_down_q, .wake_en_q, .pin_int_sel_q);
    always #2 ref_clk = ~ref_clk;
    // Sources are scaled to periods of 6 and 10 cycles to keep the run short.
    always @(posedge ref_clk) begin
        ph <= ph + 1;
        internal_rc_oscillator <= (ph % 6) < 3;
        pll_clk_in <= (ph % 10) < 5;
    end
    // ================================================================
    // Tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        @(posedge ref_clk);
        while (apb_rsp.pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge ref_clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, x);
        check({31'h0, e}, {31'h0, xe});
    endtask : rd
    // Index 0 counts main clock rises, the others count high samples.
    task automatic count(input int sel);
        logic p;
        logic [4:0] v;
        c = 32'h0;
        p = main_clk_q;
        repeat (60) begin
            @(negedge ref_clk);
            v = {periph_clk_en_q[1:0], serial_clk_tick_q, sys_clk_tick_q, main_clk_q && !p};
            c = c + 32'(v[sel]);
            p = main_clk_q;
        end
        // Return just after a rising edge so that bus tasks start there.
        @(posedge ref_clk);
    endtask : count
    task automatic print_verdict;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #20000;
        mismatches++;
        print_verdict();
    end
    // ================================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        foreach (rows[i]) begin
            rd(rows[i].a, rows[i].r, rows[i].e);
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].q, rows[i].e);
        end
        check(periph_rst_n_q, 32'hAAA);
        check({16'h0, power_down_q}, 32'hDF0);
        check(wake_en_q, 32'h81);
        check(xtal_osc_ctrl_q, 32'h3);
        check({pll_ctrl_q[15:0], wdt_osc_ctrl_q[15:0]}, 32'h0023_0041);
        check({pin_int_sel_q[63:56], pin_int_sel_q[7:0]}, 32'hA55A);
        count(0); check(c, 32'd10);
        count(1); check(c, 32'd10);
        count(2); check(c, 32'd5);
        count(3); check(c, 32'd10);
        wr(12'h080, 32'h1);
        count(4); check(c, 32'd0);
        wr(12'h078, 32'h0);
        count(1); check(c, 32'd0);
        wr(12'h078, 32'h2);
        repeat (12) @(posedge ref_clk);
        count(1); check(c, 32'd5);
        wr(12'h040, 32'h1);
        check({30'h0, pll_in_active_q}, 32'h0);
        wr(12'h044, 32'h0);
        wr(12'h044, 32'h1);
        check({30'h0, pll_in_active_q}, 32'h1);
        pll_lock_in <= 1'b1;
        wr(12'h070, 32'h3);
        count(0); check(c, 32'd10);
        rd(12'h00C, 32'h1, 1'b0);
        wr(12'h074, 32'h0);
        wr(12'h074, 32'h1);
        repeat (30) @(posedge ref_clk);
        count(0); check(c, 32'd6);
        wr(12'h070, 32'h0);
        wr(12'h074, 32'h1);
        repeat (30) @(posedge ref_clk);
        count(0); check(c, 32'd6);
        wr(12'h074, 32'h0);
        wr(12'h074, 32'h1);
        repeat (30) @(posedge ref_clk);
        count(0); check(c, 32'd10);
        rstn <= 1'b0;
        // Released on a low phase of the oscillator so the first pulse is whole.
        repeat (4) @(posedge ref_clk);
        check({30'h0, mem_remap_q}, 32'h2);
        check(periph_rst_n_q, 32'h1FFF);
        rstn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        count(0); check(c, 32'd10);
        print_verdict();
    end
endmodule : scc_system_clock_config_test
bind scc_system_clock_config scc_system_clock_config_sva scc_system_clock_config_sva_inst (
    .ref_clk, .rstn, .apb_req, .apb_rsp, .internal_rc_oscillator, .main_clk_q,
    .sys_clk_tick_q, .core_clk_en_q, .periph_clk_en_q, .serial_clk_tick_q,
    .periph_rst_n_q, .power_down_q);
`default_nettype wire
